/* File: core/dac_output_state_control.v */
`timescale 1ns/1ps
`include "dac_ctl_defs.vh"

module dac_output_state_control
#(
  parameter DATA_W = 18
)
(
  input  wire              i_clock,
  input  wire              i_rstn,
  input  wire              i_load_pin_n,
  input  wire              i_clear_pin_n,
  input  wire [7:0]        i_awaddr,
  input  wire              i_awvalid,
  output wire              o_awready,
  input  wire [31:0]       i_wdata,
  input  wire [3:0]        i_wstrb,
  input  wire              i_wvalid,
  output wire              o_wready,
  output reg  [1:0]        o_bresp,
  output reg               o_bvalid,
  input  wire              i_bready,
  input  wire [7:0]        i_araddr,
  input  wire              i_arvalid,
  output wire              o_arready,
  output reg  [31:0]       o_rdata,
  output reg  [1:0]        o_rresp,
  output reg               o_rvalid,
  input  wire              i_rready,
  output reg  [DATA_W-1:0] o_dac_code,
  output reg               o_offset_binary,
  output reg               o_fb_comp_sel,
  output reg  [1:0]        o_output_state,
  output reg               o_load_pulse
);

  // ----------------------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------------------
  reg  [DATA_W-1:0] pending_r;
  reg  [DATA_W-1:0] clear_code_r;
  reg  [4:0]        control_r;
  reg               aw_hold_r;
  reg               w_hold_r;
  reg  [7:0]        awaddr_r;
  reg  [31:0]       wdata_r;
  reg  [3:0]        wstrb_r;
  wire              do_write;
  wire              load_strobe;
  wire              clear_strobe;
  wire [1:0]        state_sel;
  wire [7:0]        wr_addr;
  wire [31:0]       wr_data;
  wire              wr_full;
  wire              sw_reset;

  assign wr_addr  = aw_hold_r ? awaddr_r : i_awaddr;
  assign wr_data  = w_hold_r ? wdata_r : i_wdata;
  assign wr_full  = w_hold_r ? (&wstrb_r) : (&i_wstrb);
  assign do_write = (aw_hold_r | i_awvalid) & (w_hold_r | i_wvalid) & ~o_bvalid;

  assign o_awready = ~aw_hold_r & ~o_bvalid;
  assign o_wready  = ~w_hold_r & ~o_bvalid;
  assign o_arready = ~o_rvalid;

  assign sw_reset = do_write & wr_full & (wr_addr == `OFS_SW_CONTROL)
                    & wr_data[`SW_RESET_BIT];

  // ----------------------------------------------------------------------------
  // Software strobe gating and output state decode
  // ----------------------------------------------------------------------------
  sw_strobe_gate u_gate
  (
    .i_write        (do_write & wr_full & (wr_addr == `OFS_SW_CONTROL)),
    .i_load_bit     (wr_data[`SW_LOAD_BIT]),
    .i_clear_bit    (wr_data[`SW_CLEAR_BIT]),
    .i_load_pin_n   (i_load_pin_n),
    .i_clear_pin_n  (i_clear_pin_n),
    .o_load_strobe  (load_strobe),
    .o_clear_strobe (clear_strobe)
  );

  output_state_select u_state
  (
    .i_tristate_sel (control_r[`CTL_TRI_BIT]),
    .i_clamp_sel    (control_r[`CTL_CLAMP_BIT]),
    .o_state        (state_sel)
  );

  // ----------------------------------------------------------------------------
  // Write channel holding
  // ----------------------------------------------------------------------------
  always @(posedge i_clock or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      aw_hold_r <= 1'b0;
      w_hold_r  <= 1'b0;
      awaddr_r  <= 8'h00;
      wdata_r   <= 32'h00000000;
      wstrb_r   <= 4'h0;
      o_bvalid  <= 1'b0;
      o_bresp   <= `RESP_OKAY;
    end
    else
    begin
      if (do_write)
      begin
        aw_hold_r <= 1'b0;
        w_hold_r  <= 1'b0;
        o_bvalid  <= 1'b1;
        if (wr_addr == `OFS_DAC_VALUE || wr_addr == `OFS_CONTROL ||
            wr_addr == `OFS_CLEAR_CODE || wr_addr == `OFS_SW_CONTROL)
          o_bresp <= `RESP_OKAY;
        else
          o_bresp <= `RESP_SLVERR;
      end
      else
      begin
        if (i_awvalid && o_awready)
        begin
          aw_hold_r <= 1'b1;
          awaddr_r  <= i_awaddr;
        end
        if (i_wvalid && o_wready)
        begin
          w_hold_r <= 1'b1;
          wdata_r  <= i_wdata;
          wstrb_r  <= i_wstrb;
        end
        if (o_bvalid && i_bready)
          o_bvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------------
  // Device registers; software reset returns all to power-on values
  // ----------------------------------------------------------------------------
  always @(posedge i_clock or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      pending_r       <= {DATA_W{1'b0}};
      clear_code_r    <= {DATA_W{1'b0}};
      control_r       <= `CTL_RESET_VAL;
      o_dac_code      <= {DATA_W{1'b0}};
      o_load_pulse    <= 1'b0;
    end
    else if (sw_reset)
    begin
      pending_r       <= {DATA_W{1'b0}};
      clear_code_r    <= {DATA_W{1'b0}};
      control_r       <= `CTL_RESET_VAL;
      o_dac_code      <= {DATA_W{1'b0}};
      o_load_pulse    <= 1'b0;
    end
    else
    begin
      o_load_pulse <= load_strobe | clear_strobe;
      if (do_write && wr_full)
      begin
        if (wr_addr == `OFS_DAC_VALUE)
          pending_r <= wr_data[DATA_W-1:0];
        if (wr_addr == `OFS_CONTROL)
          control_r <= wr_data[4:0];
        if (wr_addr == `OFS_CLEAR_CODE)
          clear_code_r <= wr_data[DATA_W-1:0];
      end
      if (clear_strobe)
        o_dac_code <= clear_code_r;
      else if (load_strobe)
        o_dac_code <= pending_r;
    end
  end

  // ----------------------------------------------------------------------------
  // Outputs driven by the control register
  // ----------------------------------------------------------------------------
  always @(posedge i_clock or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      o_output_state  <= `OUT_CLAMPED;
      o_offset_binary <= 1'b0;
      o_fb_comp_sel   <= 1'b0;
    end
    else if (sw_reset)
    begin
      // Output returns to the clamped power-on state at the reset edge itself
      o_output_state  <= `OUT_CLAMPED;
      o_offset_binary <= 1'b0;
      o_fb_comp_sel   <= 1'b0;
    end
    else
    begin
      o_output_state  <= state_sel;
      o_offset_binary <= control_r[`CTL_CODING_BIT];
      o_fb_comp_sel   <= control_r[`CTL_FB_COMP_BIT];
    end
  end

  // ----------------------------------------------------------------------------
  // Read channel; software control reads as zero
  // ----------------------------------------------------------------------------
  always @(posedge i_clock or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      o_rvalid <= 1'b0;
      o_rdata  <= 32'h00000000;
      o_rresp  <= `RESP_OKAY;
    end
    else if (i_arvalid && o_arready)
    begin
      o_rvalid <= 1'b1;
      o_rresp  <= `RESP_OKAY;
      case (i_araddr)
        `OFS_DAC_VALUE:  o_rdata <= {{(32-DATA_W){1'b0}}, pending_r};
        `OFS_CONTROL:    o_rdata <= {27'h0000000, control_r};
        `OFS_CLEAR_CODE: o_rdata <= {{(32-DATA_W){1'b0}}, clear_code_r};
        `OFS_SW_CONTROL: o_rdata <= 32'h00000000;
        `OFS_STATUS:     o_rdata <= {{(30-DATA_W){1'b0}}, o_output_state, o_dac_code};
        default:
        begin
          o_rdata <= 32'h00000000;
          o_rresp <= `RESP_SLVERR;
        end
      endcase
    end
    else if (o_rvalid && i_rready)
      o_rvalid <= 1'b0;
  end

endmodule

/* File: core/output_state_select.v */
`timescale 1ns/1ps
`include "dac_ctl_defs.vh"

module output_state_select
(
  input  wire       i_tristate_sel,
  input  wire       i_clamp_sel,
  output reg  [1:0] o_state
);

  always @*
  begin
    if (i_clamp_sel)
      o_state = `OUT_CLAMPED;
    else if (i_tristate_sel)
      o_state = `OUT_TRISTATE;
    else
      o_state = `OUT_NORMAL;
  end

endmodule

/* File: core/sw_strobe_gate.v */
`timescale 1ns/1ps
`include "dac_ctl_defs.vh"

module sw_strobe_gate
(
  input  wire i_write,
  input  wire i_load_bit,
  input  wire i_clear_bit,
  input  wire i_load_pin_n,
  input  wire i_clear_pin_n,
  output wire o_load_strobe,
  output wire o_clear_strobe
);

  // ----------------------------------------------------------------------------
  // Bits set to 1 act as single pulses, gated by the opposite pin
  // ----------------------------------------------------------------------------
  assign o_load_strobe  = i_write & i_load_bit & i_clear_pin_n;
  assign o_clear_strobe = i_write & i_clear_bit & i_load_pin_n;

endmodule

/* File: pkg/dac_ctl_defs.vh */
`ifndef DAC_CTL_DEFS_VH
`define DAC_CTL_DEFS_VH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define OFS_DAC_VALUE    8'h00
`define OFS_CONTROL      8'h04
`define OFS_CLEAR_CODE   8'h08
`define OFS_SW_CONTROL   8'h0C
`define OFS_STATUS       8'h10

// ----------------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------------
`define CTL_FB_COMP_BIT  1
`define CTL_TRI_BIT      2
`define CTL_CLAMP_BIT    3
`define CTL_CODING_BIT   4
`define CTL_RESET_VAL    5'h0C

// ----------------------------------------------------------------------------
// Software control fields
// ----------------------------------------------------------------------------
`define SW_LOAD_BIT      0
`define SW_CLEAR_BIT     1
`define SW_RESET_BIT     2

// ----------------------------------------------------------------------------
// Output states and bus answers
// ----------------------------------------------------------------------------
`define OUT_NORMAL       2'h0
`define OUT_TRISTATE     2'h1
`define OUT_CLAMPED      2'h2
`define RESP_OKAY        2'h0
`define RESP_SLVERR      2'h2

`endif

/* File: tb/axi_host.sv */
`timescale 1ns/1ps
module axi_host
(
  input wire        i_clock, i_awready, i_wready, i_bvalid, i_arready, i_rvalid,
  output reg [7:0]  o_awaddr, o_araddr,
  output reg [31:0] o_wdata,
  output reg [3:0]  o_wstrb,
  output reg        o_awvalid, o_wvalid, o_bready, o_arvalid, o_rready, o_tmo
);
  initial {o_awaddr, o_araddr, o_wdata, o_wstrb, o_awvalid, o_wvalid, o_bready} = 0;
  initial {o_arvalid, o_rready, o_tmo} = 0;
  task wr(input [7:0] a, input [31:0] d, input [3:0] s);
    integer n;
    begin
      @(posedge i_clock);
      {o_awaddr, o_wdata, o_wstrb} <= {a, d, s};
      {o_awvalid, o_wvalid} <= 2'h3;
      for (n = 0; n < 99; n = n + 1)
      begin
        @(posedge i_clock);
        if (i_awready) o_awvalid <= 1'b0;
        // Released payload no longer shows the old value
        if (i_wready) o_wdata <= ~d;
        if (i_wready) o_wvalid <= 1'b0;
        // Late ready makes the answer stand for a stalled cycle
        if (i_bvalid && o_bready) n = 200;
        else if (n == 1) o_bready <= 1'b1;
      end
      o_bready <= 1'b0;
      if (n == 99) o_tmo <= 1'b1;
    end
  endtask
  task rd(input [7:0] a);
    integer n;
    begin
      @(posedge i_clock);
      {o_araddr, o_arvalid} <= {a, 1'b1};
      for (n = 0; n < 99; n = n + 1)
      begin
        @(posedge i_clock);
        if (i_arready) o_arvalid <= 1'b0;
        if (i_rvalid && o_rready) n = 200;
        else if (n == 1) o_rready <= 1'b1;
      end
      {o_araddr, o_rready} <= {~a, 1'b0};
      if (n == 99) o_tmo <= 1'b1;
    end
  endtask
endmodule

/* File: tb/dac_ctl_chk.sv */
`timescale 1ns/1ps
`include "dac_ctl_defs.vh"
module dac_ctl_chk #(parameter DATA_W = 18)
(
  input wire              i_clock, i_rstn, i_load_pin_n, i_clear_pin_n,
  input wire [7:0]        i_awaddr,
  input wire              i_awvalid, o_awready, i_wvalid, o_wready, i_bready, i_rready,
  input wire [31:0]       i_wdata, o_rdata,
  input wire [3:0]        i_wstrb,
  input wire              o_bvalid, o_rvalid, o_fb_comp_sel, o_load_pulse,
  input wire [1:0]        o_bresp, o_output_state,
  input wire [DATA_W-1:0] o_dac_code
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rstn);
  wire wr     = i_awvalid && o_awready && i_wvalid && o_wready && !o_bvalid && i_wstrb == 4'hF;
  wire sw_wr  = wr && i_awaddr == `OFS_SW_CONTROL;
  wire ctl_wr = wr && i_awaddr == `OFS_CONTROL;
  property p_bhold; o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp); endproperty
  a_bhold: assert property (p_bhold) else $error("write answer dropped early");
  property p_rhold; o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata); endproperty
  a_rhold: assert property (p_rhold) else $error("read answer dropped early");
  property p_load; sw_wr && i_wdata[2:0] == 3'h1 && i_clear_pin_n |=> o_load_pulse; endproperty
  a_load: assert property (p_load) else $error("load strobe gave no pulse");
  property p_load_gate;
    sw_wr && i_wdata[2:0] == 3'h1 && !i_clear_pin_n |=> $stable(o_dac_code) && !o_load_pulse;
  endproperty
  a_load_gate: assert property (p_load_gate) else $error("load acted with clear pin low");
  property p_clr_gate;
    sw_wr && i_wdata[2:0] == 3'h2 && !i_load_pin_n |=> $stable(o_dac_code) && !o_load_pulse;
  endproperty
  a_clr_gate: assert property (p_clr_gate) else $error("clear acted with load pin low");
  property p_zero;
    sw_wr && i_wdata[2:0] == 3'h0 |=> $stable(o_dac_code) && !o_load_pulse;
  endproperty
  a_zero: assert property (p_zero) else $error("zero control write acted");
  property p_pulse; o_load_pulse |=> !o_load_pulse; endproperty
  a_pulse: assert property (p_pulse) else $error("strobe retained");
  property p_state;
    ctl_wr |-> ##2 o_output_state == ($past(i_wdata[3], 2) ? `OUT_CLAMPED :
      $past(i_wdata[2], 2) ? `OUT_TRISTATE : `OUT_NORMAL);
  endproperty
  a_state: assert property (p_state) else $error("output state wrong");
  property p_rst;
    sw_wr && i_wdata[2] |-> ##2 o_output_state == `OUT_CLAMPED && o_dac_code == 0 && !o_fb_comp_sel;
  endproperty
  a_rst: assert property (p_rst) else $error("software reset incomplete");
  c_clear: cover property (sw_wr && i_wdata[1:0] == 2'h2 && i_load_pin_n);
  c_normal: cover property (ctl_wr && i_wdata[3:2] == 2'h0);
  c_pulse: cover property (o_load_pulse);
  c_bstall: cover property (o_bvalid && !i_bready);
endmodule
bind dac_output_state_control dac_ctl_chk #(.DATA_W(DATA_W)) chk (.*);

/* File: tb/test_dac_output_state_control.sv */
`timescale 1ns/1ps
`include "dac_ctl_defs.vh"
module test_dac_output_state_control;
  reg          i_clock = 0, i_rstn = 0, i_load_pin_n = 1, i_clear_pin_n = 1;
  wire [7:0]   i_awaddr, i_araddr;
  wire [31:0]  i_wdata, o_rdata;
  wire [3:0]   i_wstrb;
  wire         i_awvalid, o_awready, i_wvalid, o_wready, o_bvalid, i_bready, tmo;
  wire         i_arvalid, o_arready, o_rvalid, i_rready, o_fb_comp_sel, o_offset_binary;
  wire         o_load_pulse;
  wire [1:0]   o_bresp, o_rresp, o_output_state;
  wire [17:0]  o_dac_code;
  integer      error_cnt = 0, comparisons = 0, seed = 44, i;
  reg [33:0]   q[$];
  reg [1:0]    bq[$];
  reg [17:0]   x, y, c;
  always #12.5 i_clock = ~i_clock;
  dac_output_state_control #(.DATA_W(18)) DUT (.*);
  axi_host host (.i_clock(i_clock), .i_awready(o_awready), .i_wready(o_wready),
    .i_bvalid(o_bvalid), .i_arready(o_arready), .i_rvalid(o_rvalid), .o_awaddr(i_awaddr),
    .o_araddr(i_araddr), .o_wdata(i_wdata), .o_wstrb(i_wstrb), .o_awvalid(i_awvalid),
    .o_wvalid(i_wvalid), .o_bready(i_bready), .o_arvalid(i_arvalid), .o_rready(i_rready),
    .o_tmo(tmo));
  task complete_run;
    begin
      $display("errors %0d comparisons %0d", error_cnt, comparisons);
      if (error_cnt == 0 && comparisons > 0)
        $display("All tests passed");
      else
        $display("Some tests failed");
      $finish;
    end
  endtask
  task chk_rd(input [33:0] g, input [33:0] e);
    begin
      comparisons = comparisons + 1;
      if (g !== e)
      begin
        error_cnt = error_cnt + 1;
        $display("mismatch at %0t: read got %h expected %h", $time, g, e);
      end
    end
  endtask
  task chk_wr(input [1:0] g, input [1:0] e);
    begin
      comparisons = comparisons + 1;
      if (g !== e)
      begin
        error_cnt = error_cnt + 1;
        $display("mismatch at %0t: write answer %h expected %h", $time, g, e);
      end
    end
  endtask
  task chk_lvl(input [1:0] g, input [1:0] e);
    begin
      comparisons = comparisons + 1;
      if (g !== e)
      begin
        error_cnt = error_cnt + 1;
        $display("mismatch at %0t: level %h expected %h", $time, g, e);
      end
    end
  endtask
  task rd(input [7:0] a, input [33:0] e);
    begin
      q.push_back(e);
      host.rd(a);
    end
  endtask
  task st(input [1:0] s, input [17:0] v);
    rd(`OFS_STATUS, {14'h0, s, v});
  endtask
  task wrs(input [7:0] a, input [31:0] d, input [3:0] s, input [1:0] e);
    begin
      bq.push_back(e);
      host.wr(a, d, s);
    end
  endtask
  task wr(input [7:0] a, input [31:0] d);
    wrs(a, d, 4'hF, `RESP_OKAY);
  endtask
  always @(posedge i_clock)
  begin
    if (o_rvalid && i_rready) chk_rd({o_rresp, o_rdata}, q.pop_front());
    if (o_bvalid && i_bready) chk_wr(o_bresp, bq.pop_front());
    if (tmo === 1'b1)
    begin
      error_cnt = error_cnt + 1;
      complete_run;
    end
  end
  initial
  begin
    repeat (5) @(posedge i_clock);
    i_rstn <= 1'b1;
    rd(`OFS_CONTROL, `CTL_RESET_VAL);
    rd(`OFS_SW_CONTROL, 34'h0);
    rd(8'h14, {`RESP_SLVERR, 32'h0});
    wrs(8'h14, 32'h0, 4'hF, `RESP_SLVERR);
    wrs(`OFS_CONTROL, 32'h0, 4'h3, `RESP_OKAY);
    rd(`OFS_CONTROL, `CTL_RESET_VAL);
    st(`OUT_CLAMPED, 18'h0);
    x = $random(seed);
    y = $random(seed);
    c = $random(seed);
    wr(`OFS_DAC_VALUE, x);
    st(`OUT_CLAMPED, 18'h0);
    wr(`OFS_CONTROL, 32'h0);
    st(`OUT_NORMAL, 18'h0);
    for (i = 0; i < 4; i = i + 1)
    begin
      wr(`OFS_CONTROL, i << 2);
      st(i[1] ? `OUT_CLAMPED : i[0] ? `OUT_TRISTATE : `OUT_NORMAL, 18'h0);
    end
    wr(`OFS_CONTROL, 32'h12);
    #1 chk_lvl({o_fb_comp_sel, o_offset_binary}, 2'h3);
    wr(`OFS_SW_CONTROL, 32'h1);
    st(`OUT_NORMAL, x);
    wr(`OFS_CLEAR_CODE, c);
    @(posedge i_clock) i_clear_pin_n <= 1'b0;
    wr(`OFS_DAC_VALUE, y);
    wr(`OFS_SW_CONTROL, 32'h1);
    st(`OUT_NORMAL, x);
    @(posedge i_clock) {i_clear_pin_n, i_load_pin_n} <= 2'h2;
    wr(`OFS_SW_CONTROL, 32'h2);
    st(`OUT_NORMAL, x);
    @(posedge i_clock) i_load_pin_n <= 1'b1;
    wr(`OFS_SW_CONTROL, 32'h2);
    st(`OUT_NORMAL, c);
    wr(`OFS_SW_CONTROL, 32'h0);
    st(`OUT_NORMAL, c);
    wr(`OFS_SW_CONTROL, 32'h1);
    st(`OUT_NORMAL, y);
    wr(`OFS_SW_CONTROL, 32'h3);
    st(`OUT_NORMAL, c);
    wr(`OFS_CONTROL, 32'h0);
    #1 chk_lvl({o_fb_comp_sel, o_offset_binary}, 2'h0);
    wr(`OFS_SW_CONTROL, 32'h4);
    rd(`OFS_CONTROL, `CTL_RESET_VAL);
    st(`OUT_CLAMPED, 18'h0);
    rd(`OFS_DAC_VALUE, 34'h0);
    wr(`OFS_DAC_VALUE, x);
    wr(`OFS_CONTROL, 32'h0);
    @(posedge i_clock) i_rstn <= 1'b0;
    repeat (2) @(posedge i_clock);
    i_rstn <= 1'b1;
    rd(`OFS_DAC_VALUE, 34'h0);
    st(`OUT_CLAMPED, 18'h0);
    complete_run;
  end
endmodule
